// >>> design/phy_indirect_register_access.sv
// Indirect register access engine towards the serial PHY control port, AXI4-Lite slave
//
// Summary of operation
// - A finished read puts the returned 16-bit value into the data register.
// - The address register reads back the value last written.
// - Writing one to control bit 8 writes the data register to the address.
// - Writing one to control bit 4 reads the address into the data register.
// - The read start bit clears itself.
// - Starting a transaction drives the completion flag at bit 0 to zero.
// - The completion flag goes to one when the PHY acknowledges the transaction; a watchdog abort leaves it at zero.
// - The completion flag stays one until reset or a new start.
// - Control bit 12 low holds the access state machine in reset.
// - Watchdog control bit 1 enables the transaction watchdog.
// - Watchdog control bit 0 is a read-only flag set by a watchdog abort.
// - The 16-bit timeout value is writable and resets to all ones.
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_cfg.svh"

module phy_indirect_register_access (
   input wire logic clk,
   input wire logic reset,
   input wire logic [`AXI_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`AXI_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic phyReq,
   output logic phyWrite,
   output logic [15:0] phyAddr,
   output logic [15:0] phyWdata,
   input wire logic phyAck,
   input wire logic [15:0] phyRdata,
   output logic irq
);
   import phy_access_pkg::*;

   localparam logic [15:0] CtrlReset = `RST_CTRL;

   access_state_s q;
   access_state_s d;
   logic expire;
   logic wrFire;
   logic launch;
   logic [`IDX_W-1:0] rdIdx;
   logic [15:0] rdWord;
   logic rdHit;
   logic [`EV_W-1:0] evSet;

   // Byte-lane merge into a 16-bit register; upper lanes have no storage
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] w,
                                           input logic [3:0] s);
      logic [15:0] r;
      r = old;
      for (int i = 0; i < 2; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   timeout_guard #(
      .CountW(16)
   ) guard (
      .clk(clk),
      .reset(reset),
      .enable(q.wdogEn),
      .busy(q.state == ENG_WAIT),
      .limit(q.timeout),
      .expire(expire)
   );

   assign rdIdx = araddr[`AXI_ADDR_W-1:2];

   always_comb begin
      rdHit = 1'b1;
      rdWord = 16'h0000;
      case (rdIdx)
         `IDX_DATA: rdWord = q.data;
         `IDX_ADDR: rdWord = q.addr;
         `IDX_CTRL: begin
            rdWord[`CTRL_RSTN_BIT] = q.engineResetLow;
            rdWord[`CTRL_WRITE_BIT] = q.writeStart;
            rdWord[`CTRL_READ_BIT] = q.readStart;
            rdWord[`CTRL_DONE_BIT] = q.done;
         end
         `IDX_WDOG_CTRL: begin
            rdWord[`WDOG_EN_BIT] = q.wdogEn;
            rdWord[`WDOG_ERR_BIT] = q.wdogErr;
         end
         `IDX_WDOG_VAL: rdWord = q.timeout;
         `IDX_IRQ_STAT: rdWord[`EV_W-1:0] = q.evStatus;
         `IDX_IRQ_CLR: rdWord = 16'h0000;
         `IDX_IRQ_EN: rdWord[`EV_W-1:0] = q.evEnable;
         default: rdHit = 1'b0;
      endcase
   end

   assign wrFire = q.awFull && q.wFull && !q.bValid;
   assign launch = (q.state == ENG_IDLE) && q.engineResetLow && (q.readStart || q.writeStart);

   always_comb begin
      d = q;
      evSet = '0;
      if (reset) begin
         d = '0;
         d.awReady = 1'b1;
         d.wReady = 1'b1;
         d.arReady = 1'b1;
         d.data = `RST_DATA;
         d.addr = `RST_ADDR;
         d.timeout = `RST_WDOG_VAL;
         d.engineResetLow = CtrlReset[`CTRL_RSTN_BIT];
         d.state = ENG_IDLE;
      end else begin
         // Write address and data channels, taken in either order
         if (awvalid && q.awReady) begin
            d.awFull = 1'b1;
            d.awIdx = awaddr[`AXI_ADDR_W-1:2];
         end
         if (wvalid && q.wReady) begin
            d.wFull = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
         end
         if (bvalid && bready) begin
            d.bValid = 1'b0;
         end

         // Start bits live one cycle: set by software, cleared on the next cycle whether or not the engine launches
         d.readStart = 1'b0;
         d.writeStart = 1'b0;

         // Engine sequencing
         case (q.state)
            ENG_IDLE: begin
               if (launch) begin
                  d.state = ENG_WAIT;
                  d.done = 1'b0;
                  d.wdogErr = 1'b0;
                  d.opWrite = q.writeStart;
                  d.phyReq = 1'b1;
                  d.phyWrite = q.writeStart;
                  d.phyAddr = q.addr;
                  d.phyWdata = q.data;
               end
            end
            ENG_WAIT: begin
               // A late acknowledge still completes; it beats the watchdog
               if (phyAck) begin
                  d.state = ENG_IDLE;
                  d.phyReq = 1'b0;
                  d.phyWrite = 1'b0;
                  d.done = 1'b1;
                  evSet[`EV_DONE_BIT] = 1'b1;
                  if (!q.opWrite) begin
                     d.data = phyRdata;
                  end
               end else if (expire) begin
                  d.state = ENG_IDLE;
                  d.phyReq = 1'b0;
                  d.phyWrite = 1'b0;
                  d.wdogErr = 1'b1;
                  evSet[`EV_WDOG_BIT] = 1'b1;
               end
            end
            default: begin
               d.state = ENG_IDLE;
               d.phyReq = 1'b0;
            end
         endcase

         // Engine reset held low drops any request in flight
         if (!q.engineResetLow) begin
            d.state = ENG_IDLE;
            d.phyReq = 1'b0;
            d.phyWrite = 1'b0;
         end

         // Register writes once both halves of the write are held
         if (wrFire) begin
            d.awFull = 1'b0;
            d.wFull = 1'b0;
            d.bValid = 1'b1;
            d.bResp = `RESP_OKAY;
            case (q.awIdx)
               `IDX_DATA: d.data = merge16(q.data, q.wData, q.wStrb);
               `IDX_ADDR: d.addr = merge16(q.addr, q.wData, q.wStrb);
               `IDX_CTRL: begin
                  if (q.wStrb[1]) begin
                     d.engineResetLow = q.wData[`CTRL_RSTN_BIT];
                     // Ignored while busy or held in reset
                     if (q.wData[`CTRL_WRITE_BIT] && q.state == ENG_IDLE && !launch &&
                         q.engineResetLow && q.wData[`CTRL_RSTN_BIT]) begin
                        d.writeStart = 1'b1;
                     end
                  end
                  if (q.wStrb[0] && q.wData[`CTRL_READ_BIT] && q.state == ENG_IDLE && !launch &&
                      q.engineResetLow && !(q.wStrb[1] && q.wData[`CTRL_WRITE_BIT])) begin
                     d.readStart = 1'b1;
                  end
               end
               `IDX_WDOG_CTRL: begin
                  if (q.wStrb[0]) begin
                     d.wdogEn = q.wData[`WDOG_EN_BIT];
                  end
               end
               `IDX_WDOG_VAL: d.timeout = merge16(q.timeout, q.wData, q.wStrb);
               `IDX_IRQ_STAT: d.bResp = `RESP_OKAY;
               `IDX_IRQ_CLR: begin
                  if (q.wStrb[0]) begin
                     d.evStatus = q.evStatus & ~q.wData[`EV_W-1:0];
                  end
               end
               `IDX_IRQ_EN: begin
                  if (q.wStrb[0]) begin
                     d.evEnable = q.wData[`EV_W-1:0];
                  end
               end
               default: d.bResp = `RESP_SLVERR;
            endcase
         end

         // Set beats clear on the same cycle
         d.evStatus = d.evStatus | evSet;
         d.irq = |(d.evStatus & d.evEnable);

         // Read channel
         if (arvalid && q.arReady) begin
            d.arReady = 1'b0;
            d.rValid = 1'b1;
            d.rData = rdWord;
            d.rResp = rdHit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            d.rValid = 1'b0;
            d.arReady = 1'b1;
         end

         d.awReady = !d.awFull && !d.bValid;
         d.wReady = !d.wFull && !d.bValid;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign awready = q.awReady;
   assign wready = q.wReady;
   assign bvalid = q.bValid;
   assign bresp = q.bResp;
   assign arready = q.arReady;
   assign rvalid = q.rValid;
   assign rdata = {16'h0000, q.rData};
   assign rresp = q.rResp;
   assign phyReq = q.phyReq;
   assign phyWrite = q.phyWrite;
   assign phyAddr = q.phyAddr;
   assign phyWdata = q.phyWdata;
   assign irq = q.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_read_start_clear: assert property (q.readStart |=> !q.readStart)
      else $error("read start bit did not clear itself");
   a_write_start_clear: assert property (q.writeStart |=> !q.writeStart)
      else $error("write start bit did not clear itself");
   a_start_clears_done: assert property (launch |=> !q.done && q.state == ENG_WAIT)
      else $error("completion flag not cleared on start");
   a_done_on_ack: assert property (q.state == ENG_WAIT && phyAck && q.engineResetLow
      |=> q.done && !phyReq)
      else $error("completion flag not set on acknowledge");
   a_done_holds: assert property (q.done && !launch |=> q.done)
      else $error("completion flag dropped without a new start");
   a_read_capture: assert property (q.state == ENG_WAIT && !q.opWrite && phyAck
      && q.engineResetLow |=> q.data == $past(phyRdata))
      else $error("read result not captured into data register");
   a_read_launch: assert property (launch && q.readStart && !q.writeStart
      |=> phyReq && !phyWrite && phyAddr == $past(q.addr))
      else $error("read not launched with held address");
   a_write_launch: assert property (launch && q.writeStart
      |=> phyReq && phyWrite && phyAddr == $past(q.addr) && phyWdata == $past(q.data))
      else $error("write not launched with held address and data");
   a_write_keeps_data: assert property (q.state == ENG_WAIT && q.opWrite && phyAck
      && !wrFire |=> q.data == $past(q.data))
      else $error("write completion disturbed the data register");
   a_engine_reset: assert property (!q.engineResetLow |=> q.state == ENG_IDLE && !phyReq)
      else $error("engine reset did not idle the state machine");
   a_no_start_in_reset: assert property (!q.engineResetLow
      |=> !q.readStart && !q.writeStart)
      else $error("start accepted while the engine was held in reset");
   a_busy_ignore: assert property (q.state == ENG_WAIT && !phyAck && !expire
      && q.engineResetLow |=> phyAddr == $past(phyAddr) && !q.readStart)
      else $error("start during busy disturbed the transaction");
   a_busy_no_start: assert property (q.state == ENG_WAIT
      |=> !q.readStart && !q.writeStart)
      else $error("start bit accepted while a transaction was outstanding");
   a_req_stable: assert property (phyReq && !phyAck && !expire && q.engineResetLow
      |=> phyReq && $stable(phyWrite) && $stable(phyAddr) && $stable(phyWdata))
      else $error("request to the PHY port changed before its acknowledge");
   a_wdog_off: assert property (!q.wdogEn |=> !expire)
      else $error("watchdog expired while disabled");
   a_wdog_abort: assert property (expire && q.state == ENG_WAIT && !phyAck
      && q.engineResetLow |=> q.wdogErr && !q.done && q.state == ENG_IDLE && !phyReq)
      else $error("watchdog expiry did not abort the transaction");
   a_error_held: assert property (q.wdogErr && !launch |=> q.wdogErr)
      else $error("watchdog error flag dropped without a new start");
   a_irq_level: assert property (q.evStatus[`EV_DONE_BIT] && q.evEnable[`EV_DONE_BIT]
      && !wrFire |=> irq)
      else $error("interrupt missing for enabled completion event");

   // Bus view of the registers, one cycle after the read address is taken; timeout value one cycle after its write fires
   a_addr_readback: assert property (arvalid && arready && rdIdx == `IDX_ADDR
      |=> rdata[15:0] == $past(q.addr))
      else $error("address register did not read back its last value");
   a_data_readback: assert property (arvalid && arready && rdIdx == `IDX_DATA
      |=> rdata[15:0] == $past(q.data))
      else $error("data register not visible on the register bus");
   a_timeout_write: assert property (wrFire && q.awIdx == `IDX_WDOG_VAL
      && q.wStrb[1:0] == 2'b11 |=> q.timeout == $past(q.wData[15:0]))
      else $error("timeout value write did not take effect");

endmodule

`default_nettype wire

// >>> design/phy_access_cfg.svh
// Register map, field positions, reset values and bus codes of the PHY access engine
`ifndef PHY_ACCESS_CFG_SVH
`define PHY_ACCESS_CFG_SVH

`define AXI_ADDR_W 20
`define IDX_W 18
`define IDX_DATA 18'h0d100
`define IDX_ADDR 18'h0d101
`define IDX_CTRL 18'h0d102
`define IDX_WDOG_CTRL 18'h0d111
`define IDX_WDOG_VAL 18'h0d112
`define IDX_IRQ_STAT 18'h0d120
`define IDX_IRQ_CLR 18'h0d121
`define IDX_IRQ_EN 18'h0d122

`define CTRL_DONE_BIT 0
`define CTRL_READ_BIT 4
`define CTRL_WRITE_BIT 8
`define CTRL_RSTN_BIT 12
`define WDOG_ERR_BIT 0
`define WDOG_EN_BIT 1
`define EV_DONE_BIT 0
`define EV_WDOG_BIT 1
`define EV_W 2

`define RST_DATA 16'h0000
`define RST_ADDR 16'h0000
`define RST_CTRL 16'h1000
`define RST_WDOG_VAL 16'hffff

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> design/phy_access_pkg.sv
// Types shared by the PHY access engine and its watchdog
`include "phy_access_cfg.svh"

package phy_access_pkg;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_WAIT = 2'b01
   } engine_state_e;

   typedef struct packed {
      logic awReady;
      logic wReady;
      logic awFull;
      logic wFull;
      logic [`IDX_W-1:0] awIdx;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [15:0] rData;
      logic [1:0] rResp;
      logic [15:0] data;
      logic [15:0] addr;
      logic [15:0] timeout;
      logic engineResetLow;
      logic writeStart;
      logic readStart;
      logic done;
      logic wdogEn;
      logic wdogErr;
      logic [`EV_W-1:0] evStatus;
      logic [`EV_W-1:0] evEnable;
      logic irq;
      engine_state_e state;
      logic opWrite;
      logic phyReq;
      logic phyWrite;
      logic [15:0] phyAddr;
      logic [15:0] phyWdata;
   } access_state_s;

   typedef struct packed {
      logic [15:0] count;
      logic expire;
   } guard_state_s;

endpackage

// >>> design/timeout_guard.sv
// Transaction watchdog: counts busy cycles and pulses on reaching the limit
`timescale 1ns/1ps
`default_nettype none

module timeout_guard #(
   parameter int CountW = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic busy,
   input wire logic [CountW-1:0] limit,
   output logic expire
);
   import phy_access_pkg::*;

   guard_state_s q;
   guard_state_s d;

   always_comb begin
      d = q;
      d.expire = 1'b0;
      if (reset) begin
         d = '0;
      end else if (busy && enable && !q.expire) begin
         // One quiet cycle after expiry, so a zero limit cannot fire twice
         if (q.count == limit) begin
            d.expire = 1'b1;
            d.count = '0;
         end else begin
            d.count = q.count + 16'h0001;
         end
      end else begin
         d.count = '0;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign expire = q.expire;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_expire_single: assert property (expire |=> !expire)
      else $error("watchdog expiry lasted more than one cycle");
   a_idle_no_count: assert property (!busy |=> q.count == 16'h0000)
      else $error("watchdog counted while nothing was outstanding");
   a_expire_at_limit: assert property (busy && enable && !q.expire && q.count == limit
      |=> expire)
      else $error("watchdog did not expire on reaching its limit");

endmodule

`default_nettype wire

// >>> test/phy_port_model.sv
// Behavioural PHY control port: acknowledges each request after a set delay unless muted
`timescale 1ns/1ps
`default_nettype none

module phy_port_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic phyReq,
   input wire logic phyWrite,
   input wire logic [15:0] phyAddr,
   input wire logic [15:0] phyWdata,
   input wire logic [7:0] delay,
   input wire logic mute,
   output logic phyAck,
   output logic [15:0] phyRdata
);
   logic [15:0] mem [0:15];
   logic [7:0] cnt;
   logic go;

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'h5a00 | 16'(i);
      end
      phyAck = 1'b0;
      phyRdata = 16'h0000;
      cnt = 8'h00;
   end

   // Mute never answers, so the watchdog path can be reached
   assign go = !reset && phyReq && !phyAck && !mute && cnt == delay;

   // Read data is only meaningful in the ack cycle; it toggles otherwise
   always @(posedge clk) begin
      phyAck <= go;
      phyRdata <= go ? mem[phyAddr[3:0]] : ~phyRdata;
      cnt <= (reset || !phyReq || phyAck || mute || go) ? 8'h00 : cnt + 8'h01;
      if (go && phyWrite) begin
         mem[phyAddr[3:0]] <= phyWdata;
      end
   end
endmodule

`default_nettype wire

// >>> test/phy_indirect_register_access_tb_top.sv
// Self-checking bench of the PHY indirect access engine
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_cfg.svh"

module phy_indirect_register_access_tb_top;
   typedef struct {
      logic [17:0] idx;
      logic [31:0] wd;
      logic [31:0] exp;
      logic [1:0] resp;
   } row_s;

   logic clk = 1'b0;
   logic reset, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready;
   logic rvalid, phyReq, phyWrite, phyAck, irq, mute;
   logic [19:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] phyAddr, phyWdata, phyRdata;
   logic [7:0] delay;
   logic [3:0] wstrb;
   int n_fail = 0;
   int check_count = 0;
   row_s rows[6] = '{
      '{`IDX_DATA, 32'h0000a5c3, 32'h0000a5c3, `RESP_OKAY},
      '{`IDX_ADDR, 32'hffff1234, 32'h00001234, `RESP_OKAY},
      '{`IDX_WDOG_VAL, 32'h00000004, 32'h00000004, `RESP_OKAY},
      '{`IDX_WDOG_CTRL, 32'h00000001, 32'h00000000, `RESP_OKAY},
      '{`IDX_IRQ_EN, 32'h00000003, 32'h00000003, `RESP_OKAY},
      '{18'h00004, 32'h0000ffff, 32'h00000000, `RESP_SLVERR}};
   logic [17:0] rIdx[5] = '{`IDX_DATA, `IDX_ADDR, `IDX_CTRL, `IDX_WDOG_VAL, `IDX_WDOG_CTRL};
   logic [31:0] rExp[5] = '{32'h0, 32'h0, 32'h1000, 32'hffff, 32'h0};

   always #10 clk = ~clk;

   phy_indirect_register_access phy_indirect_register_access_i (
      .clk(clk), .reset(reset), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .phyReq(phyReq), .phyWrite(phyWrite), .phyAddr(phyAddr),
      .phyWdata(phyWdata), .phyAck(phyAck), .phyRdata(phyRdata), .irq(irq));

   phy_port_model phy_port_model_i (
      .clk(clk), .reset(reset), .phyReq(phyReq), .phyWrite(phyWrite), .phyAddr(phyAddr),
      .phyWdata(phyWdata), .delay(delay), .mute(mute), .phyAck(phyAck), .phyRdata(phyRdata));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic hang();
      n_fail++;
      $display("MISMATCH t=%0t wait limit reached", $time);
      end_sim();
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [17:0] idx, input logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 64) hang();
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [17:0] idx, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 64) hang();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Software side polls a flag with a bounded number of reads
   task automatic poll(input logic [17:0] idx, input int b);
      int i;
      for (i = 0; i < 40; i++) begin
         rdr(idx, rd, rs);
         if (rd[b] === 1'b1) break;
      end
      if (i == 40) hang();
   endtask

   initial begin
      reset <= 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, mute} <= '0;
      awaddr <= '0;
      araddr <= '0;
      wdata <= '0;
      wstrb <= 4'hf;
      delay <= 8'd30;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         wr(rows[k].idx, rows[k].wd, rs);
         chk_val({30'h0, rs}, {30'h0, rows[k].resp}, "write resp");
         rdr(rows[k].idx, rd, rs);
         chk_val(rd, rows[k].exp, "readback");
         chk_val({30'h0, rs}, {30'h0, rows[k].resp}, "read resp");
      end
      // Byte lanes: only the low byte of the data register is written
      wstrb <= 4'h1;
      wr(`IDX_DATA, 32'h000012ff, rs);
      wstrb <= 4'hf;
      rdr(`IDX_DATA, rd, rs);
      chk_val(rd, 32'h0000a5ff, "low lane only");
      // Write access, with a second start issued while it is outstanding
      wr(`IDX_DATA, 32'h0000beef, rs);
      wr(`IDX_ADDR, 32'h00000005, rs);
      wr(`IDX_CTRL, 32'h00001100, rs);
      rdr(`IDX_CTRL, rd, rs);
      chk_val(rd, 32'h00001000, "busy ctrl");
      wr(`IDX_ADDR, 32'h00000009, rs);
      wr(`IDX_CTRL, 32'h00001010, rs);
      poll(`IDX_CTRL, `CTRL_DONE_BIT);
      chk_val({16'h0, phy_port_model_i.mem[5]}, 32'h0000beef, "phy word 5");
      chk_val({16'h0, phy_port_model_i.mem[9]}, 32'h00005a09, "phy word 9");
      rdr(`IDX_DATA, rd, rs);
      chk_val(rd, 32'h0000beef, "data kept");
      rdr(`IDX_CTRL, rd, rs);
      chk_val(rd, 32'h00001001, "done held");
      chk_val({31'h0, irq}, 32'h1, "irq on done");
      wr(`IDX_IRQ_CLR, 32'h1, rs);
      wr(`IDX_IRQ_EN, 32'h0, rs);
      delay <= 8'd2;
      // Read access with the interrupt masked
      wr(`IDX_CTRL, 32'h00001010, rs);
      poll(`IDX_CTRL, `CTRL_DONE_BIT);
      rdr(`IDX_CTRL, rd, rs);
      chk_val(rd, 32'h00001001, "read start cleared");
      rdr(`IDX_DATA, rd, rs);
      chk_val(rd, 32'h00005a09, "read result");
      chk_val({31'h0, irq}, 32'h0, "irq masked");
      rdr(`IDX_IRQ_STAT, rd, rs);
      chk_val(rd, 32'h1, "irq status");
      wr(`IDX_IRQ_EN, 32'h3, rs);
      repeat (2) @(posedge clk);
      chk_val({31'h0, irq}, 32'h1, "irq unmasked");
      wr(`IDX_IRQ_CLR, 32'h1, rs);
      repeat (2) @(posedge clk);
      chk_val({31'h0, irq}, 32'h0, "irq cleared");
      // Engine reset drops a request that never gets an answer
      mute <= 1'b1;
      wr(`IDX_CTRL, 32'h00001010, rs);
      wr(`IDX_CTRL, 32'h00000000, rs);
      repeat (2) @(posedge clk);
      chk_val({31'h0, phyReq}, 32'h0, "engine reset drop");
      wr(`IDX_CTRL, 32'h00001000, rs);
      rdr(`IDX_CTRL, rd, rs);
      chk_val(rd, 32'h00001000, "engine released");
      // Watchdog abort with a limit of 4 cycles
      wr(`IDX_WDOG_CTRL, 32'h2, rs);
      wr(`IDX_CTRL, 32'h00001010, rs);
      poll(`IDX_WDOG_CTRL, `WDOG_ERR_BIT);
      chk_val(rd, 32'h3, "watchdog error");
      chk_val({31'h0, phyReq}, 32'h0, "abort drop");
      rdr(`IDX_CTRL, rd, rs);
      chk_val(rd, 32'h00001000, "abort no done");
      rdr(`IDX_IRQ_STAT, rd, rs);
      chk_val(rd, 32'h2, "abort event");
      mute <= 1'b0;
      delay <= 8'd0;
      wr(`IDX_CTRL, 32'h00001100, rs);
      poll(`IDX_CTRL, `CTRL_DONE_BIT);
      rdr(`IDX_WDOG_CTRL, rd, rs);
      chk_val(rd, 32'h2, "error cleared");
      // Second system reset in mid-run
      reset <= 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         rdr(rIdx[k], rd, rs);
         chk_val(rd, rExp[k], "reset value");
      end
      end_sim();
   end
endmodule

`default_nettype wire
